// File: pkg/sar_adc_pkg.sv
// Operation
// - A conversion of one channel lasts exactly 11 conversion clock cycles.
// - Conversion clock is master clock over twice (prescaler plus one), prescaler 0..63.
// - A finished conversion stores its result per channel and sets its end flag.
// - End flags can raise the interrupt and clear when their result is read.
// - A new result over an unread one sets that channel's overrun flag.
// - Results are 10 bits after reset; the resolution bit selects 8 bits.
// - In 8-bit mode the two upper result bits read zero.
// - Writing the start bit starts a sequence over the enabled channels.
// - A software start clears all end flags as the sequence begins.
// - Hardware trigger is a timer output or the external pin, per select field.
// - Select codes 0..5 are timers, 6 the external pin, 7 reserved.
// - Hardware triggers start conversions only while trigger enable is set.
// - Each rising edge of the selected trigger is a start request.
// - One start converts every enabled channel in turn, then waits idle.
// - Channels are enabled or disabled by write-one bits; zero does nothing.
// - In sleep mode the analog cell is off while the sequencer is idle.
// - In sleep mode a start powers the cell and waits its start-up time.
// - In sleep mode the cell is switched off after the sequence ends.
package sar_adc_pkg;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int NUM_CH     = 4;
  localparam int CH_IDX_W   = 2;
  localparam int RESULT_W   = 10;
  localparam int NARROW_W   = 8;
  localparam int DIVIDER_W  = 6;
  localparam int HW_SEL_W   = 3;
  localparam int NUM_TIMER  = 6;
  localparam int NUM_TRIG   = 7;
  localparam int STAT_W     = 12;
  localparam int EDGE_W     = 4;
  localparam int WAKE_W     = 12;
  localparam logic [AXI_ADDR_W-1:0] OFF_CTRL    = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] OFF_MODE    = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OFF_CH_ON   = 8'h10;
  localparam logic [AXI_ADDR_W-1:0] OFF_CH_OFF  = 8'h14;
  localparam logic [AXI_ADDR_W-1:0] OFF_CH_STAT = 8'h18;
  localparam logic [AXI_ADDR_W-1:0] OFF_STATUS  = 8'h20;
  localparam logic [AXI_ADDR_W-1:0] OFF_IRQ_ON  = 8'h24;
  localparam logic [AXI_ADDR_W-1:0] OFF_IRQ_OFF = 8'h28;
  localparam logic [AXI_ADDR_W-1:0] OFF_IRQ_MSK = 8'h2C;
  localparam logic [AXI_ADDR_W-1:0] OFF_RESULT0 = 8'h30;
  localparam int CTRL_SWRST_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int MODE_HW_EN_BIT = 0;
  localparam int MODE_HW_SEL_LSB = 1;
  localparam int MODE_NARROW_BIT = 4;
  localparam int MODE_SLEEP_BIT = 5;
  localparam int MODE_DIV_LSB   = 8;
  localparam logic [HW_SEL_W-1:0] HW_SEL_EXT  = 3'h6;
  localparam logic [HW_SEL_W-1:0] HW_SEL_RSVD = 3'h7;
  localparam logic [AXI_DATA_W-1:0] MODE_WR_MASK = 32'h00003F3F;
  localparam logic [AXI_DATA_W-1:0] MODE_RESET   = 32'h00000000;
  localparam logic [STAT_W-1:0] STAT_MASK = 12'hF0F;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CONV_CLK_CYCLES = 11;
  localparam int CLK_PERIOD_NS   = 100;
  localparam int STARTUP_TIME_NS = 20000;
  localparam int STARTUP_CYCLES  = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {S_IDLE, S_WAKE, S_PICK, S_WAIT} seq_state_t;
endpackage

// File: pkg/conv_if.sv
`timescale 1ns/10ps
interface conv_if;
  logic                             start;
  logic                             abort;
  logic [sar_adc_pkg::CH_IDX_W-1:0]  chan;
  logic [sar_adc_pkg::DIVIDER_W-1:0] div;
  logic                             busy;
  logic                             done;
  logic [sar_adc_pkg::RESULT_W-1:0]  result;
  modport ctrl (output start, abort, chan, div, input busy, done, result);
  modport eng (input start, abort, chan, div, output busy, done, result);
endinterface

// File: design/sar_conv_engine.sv
`timescale 1ns/10ps
module sar_conv_engine (
  input  wire logic                             sys_clk,
  input  wire logic                             nrst,
  conv_if.eng                                   cv,
  output logic                                  cell_clk,
  output logic [sar_adc_pkg::CH_IDX_W-1:0]       cell_chan,
  output logic                                  cell_active,
  input  wire logic [sar_adc_pkg::RESULT_W-1:0]  cell_data
);
  import sar_adc_pkg::*;
  localparam logic [EDGE_W-1:0] LAST_EDGE = EDGE_W'(CONV_CLK_CYCLES - 1);
  logic [DIVIDER_W-1:0] div_q, div_d, cnt_q, cnt_d;
  logic                 clk_q, clk_d, busy_q, busy_d, done_q, done_d;
  logic [EDGE_W-1:0]    edge_q, edge_d;
  logic [CH_IDX_W-1:0]  chan_q, chan_d;
  logic [RESULT_W-1:0]  result_q, result_d;
  logic [12:0]          cyc_q;

  // Prescaler reload is latched per conversion so a mode write cannot stretch it
  always_comb begin
    div_d = div_q;
    cnt_d = cnt_q;
    clk_d = clk_q;
    busy_d = busy_q;
    done_d = 1'b0;
    edge_d = edge_q;
    chan_d = chan_q;
    result_d = result_q;
    if (cv.abort) begin
      busy_d = 1'b0;
      clk_d = 1'b0;
    end else if (!busy_q) begin
      if (cv.start) begin
        busy_d = 1'b1;
        div_d = cv.div;
        cnt_d = cv.div;
        clk_d = 1'b0;
        edge_d = '0;
        chan_d = cv.chan;
      end
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end else begin
      cnt_d = div_q;
      clk_d = !clk_q;
      if (clk_q) begin
        if (edge_q == LAST_EDGE) begin
          busy_d = 1'b0;
          done_d = 1'b1;
          result_d = cell_data;
        end else begin
          edge_d = edge_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= '0;
      cnt_q <= '0;
      clk_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      edge_q <= '0;
      chan_q <= '0;
      result_q <= '0;
    end else begin
      div_q <= div_d;
      cnt_q <= cnt_d;
      clk_q <= clk_d;
      busy_q <= busy_d;
      done_q <= done_d;
      edge_q <= edge_d;
      chan_q <= chan_d;
      result_q <= result_d;
    end
  end

  assign cell_clk    = clk_q;
  assign cell_chan   = chan_q;
  assign cell_active = busy_q;
  assign cv.busy     = busy_q;
  assign cv.done     = done_q;
  assign cv.result   = result_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) cyc_q <= '0;
    else if (cv.start && !busy_q) cyc_q <= '0;
    else if (busy_q) cyc_q <= cyc_q + 1'b1;
  end

  a_conv_length: assert property (@(posedge sys_clk) disable iff (!nrst)
    cv.done |-> int'(cyc_q) == 2 * CONV_CLK_CYCLES * (int'(div_q) + 1))
    else $error("conversion length wrong");
endmodule // sar_conv_engine

// File: design/sar_adc_sequencer.sv
`timescale 1ns/10ps
module sar_adc_sequencer #(
  parameter int WAKE_CYCLES = sar_adc_pkg::STARTUP_CYCLES
) (
  input  wire logic                                sys_clk,
  input  wire logic                                nrst,
  input  wire logic [sar_adc_pkg::AXI_ADDR_W-1:0]   awaddr,
  input  wire logic                                awvalid,
  output logic                                     awready,
  input  wire logic [sar_adc_pkg::AXI_DATA_W-1:0]   wdata,
  input  wire logic [3:0]                          wstrb,
  input  wire logic                                wvalid,
  output logic                                     wready,
  output logic [1:0]                               bresp,
  output logic                                     bvalid,
  input  wire logic                                bready,
  input  wire logic [sar_adc_pkg::AXI_ADDR_W-1:0]   araddr,
  input  wire logic                                arvalid,
  output logic                                     arready,
  output logic [sar_adc_pkg::AXI_DATA_W-1:0]        rdata,
  output logic [1:0]                               rresp,
  output logic                                     rvalid,
  input  wire logic                                rready,
  input  wire logic [sar_adc_pkg::NUM_TIMER-1:0]    timer_wave_output,
  input  wire logic                                ext_trigger_pin_0,
  input  wire logic [sar_adc_pkg::RESULT_W-1:0]     cell_data,
  output logic                                     cell_clk,
  output logic [sar_adc_pkg::CH_IDX_W-1:0]          cell_chan,
  output logic                                     cell_active,
  output logic                                     cell_power,
  output logic                                     conv_irq
);
  import sar_adc_pkg::*;

  function automatic logic [AXI_DATA_W-1:0] strb_mask(input logic [3:0] s);
    logic [AXI_DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) m[i*8 +: 8] = {8{s[i]}};
    return m;
  endfunction

  function automatic logic hit(input logic [AXI_ADDR_W-1:0] a, input logic [AXI_ADDR_W-1:0] o);
    return a[AXI_ADDR_W-1:2] == o[AXI_ADDR_W-1:2];
  endfunction

  function automatic logic is_result(input logic [AXI_ADDR_W-1:0] a);
    return a[AXI_ADDR_W-1:4] == OFF_RESULT0[AXI_ADDR_W-1:4];
  endfunction

  function automatic logic known(input logic [AXI_ADDR_W-1:0] a);
    return hit(a, OFF_CTRL) || hit(a, OFF_MODE) || hit(a, OFF_CH_ON) || hit(a, OFF_CH_OFF)
      || hit(a, OFF_CH_STAT) || hit(a, OFF_STATUS) || hit(a, OFF_IRQ_ON)
      || hit(a, OFF_IRQ_OFF) || hit(a, OFF_IRQ_MSK) || is_result(a);
  endfunction

  // Reserved code and out-of-range selects give no edge
  function automatic logic pick_trigger(input logic [HW_SEL_W-1:0] sel,
                                        input logic [NUM_TRIG-1:0] rise);
    return (sel == HW_SEL_RSVD) ? 1'b0 : rise[sel];
  endfunction

  function automatic logic [CH_IDX_W-1:0] first_ch(input logic [NUM_CH-1:0] m);
    logic [CH_IDX_W-1:0] idx;
    idx = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) if (m[i]) idx = CH_IDX_W'(i);
    return idx;
  endfunction

  conv_if cv ();

  sar_conv_engine u_engine (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .cv          (cv),
    .cell_clk    (cell_clk),
    .cell_chan   (cell_chan),
    .cell_active (cell_active),
    .cell_data   (cell_data)
  );

  // Per-source edges, so changing the select never fakes an edge
  logic [NUM_TRIG-1:0] trig_s1_q, trig_s2_q, trig_s3_q, trig_rise;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      trig_s1_q <= '0;
      trig_s2_q <= '0;
      trig_s3_q <= '0;
    end else begin
      trig_s1_q <= {ext_trigger_pin_0, timer_wave_output};
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end
  assign trig_rise = trig_s2_q & ~trig_s3_q;

  logic                  aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [AXI_ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [AXI_DATA_W-1:0] w_data_q, w_data_d, rdata_q, rdata_d, rd_mux;
  logic [3:0]            w_strb_q, w_strb_d;
  logic                  bvalid_q, bvalid_d, rvalid_q, rvalid_d, rd_ok;
  logic [1:0]            bresp_q, bresp_d, rresp_q, rresp_d;
  logic                  wr_fire, ar_fire;

  assign awready = !aw_hold_q && !bvalid_q;
  assign wready  = !w_hold_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign wr_fire = aw_hold_q && w_hold_q;
  assign ar_fire = arvalid && arready;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;

  always_comb begin
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d = w_hold_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (awvalid && awready) begin
      aw_hold_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_hold_d = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (wr_fire) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = known(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (ar_fire) begin
      rvalid_d = 1'b1;
      rdata_d = rd_mux;
      rresp_d = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_hold_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else begin
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q <= w_hold_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  seq_state_t            state_q, state_d;
  logic [AXI_DATA_W-1:0] mode_q, mode_d, wr_eff, wr_m;
  logic [NUM_CH-1:0]     ch_en_q, ch_en_d, eoc_q, eoc_d, ovr_q, ovr_d, rem_q, rem_d, rd_clr;
  logic [STAT_W-1:0]     imr_q, imr_d, stat_q, stat_d;
  logic [CH_IDX_W-1:0]   ch_q, ch_d;
  logic [WAKE_W-1:0]     wake_q, wake_d;
  logic [RESULT_W-1:0]   rslt_q [NUM_CH];
  logic [RESULT_W-1:0]   rslt_d [NUM_CH];
  logic [RESULT_W-1:0]   capture;
  logic                  irq_q, irq_d, sw_start, soft_rst, hw_start, start_req, sleep;

  assign wr_eff    = w_data_q & strb_mask(w_strb_q);
  assign wr_m      = strb_mask(w_strb_q) & MODE_WR_MASK;
  assign sw_start  = wr_fire && hit(aw_addr_q, OFF_CTRL) && wr_eff[CTRL_START_BIT];
  assign soft_rst  = wr_fire && hit(aw_addr_q, OFF_CTRL) && wr_eff[CTRL_SWRST_BIT];
  assign hw_start  = mode_q[MODE_HW_EN_BIT]
    && pick_trigger(mode_q[MODE_HW_SEL_LSB +: HW_SEL_W], trig_rise);
  assign start_req = sw_start || hw_start;
  assign sleep     = mode_q[MODE_SLEEP_BIT];
  assign stat_q    = {ovr_q, 4'h0, eoc_q};
  assign rd_clr    = (ar_fire && is_result(araddr)) ? NUM_CH'(1) << araddr[3:2] : '0;
  assign capture   = mode_q[MODE_NARROW_BIT]
    ? RESULT_W'(cv.result[NARROW_W-1:0]) : cv.result;

  assign cv.start = (state_q == S_PICK) && (rem_q != '0);
  assign cv.chan  = first_ch(rem_q);
  assign cv.div   = mode_q[MODE_DIV_LSB +: DIVIDER_W];
  assign cv.abort = soft_rst;

  always_comb begin
    rd_ok = 1'b1;
    rd_mux = '0;
    if (hit(araddr, OFF_MODE)) rd_mux = mode_q;
    else if (hit(araddr, OFF_CH_STAT)) rd_mux = AXI_DATA_W'(ch_en_q);
    else if (hit(araddr, OFF_STATUS)) rd_mux = AXI_DATA_W'(stat_q);
    else if (hit(araddr, OFF_IRQ_MSK)) rd_mux = AXI_DATA_W'(imr_q);
    else if (is_result(araddr)) rd_mux = AXI_DATA_W'(rslt_q[araddr[3:2]]);
    else rd_ok = known(araddr);
  end

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    ch_en_d = ch_en_q;
    imr_d = imr_q;
    rem_d = rem_q;
    ch_d = ch_q;
    wake_d = wake_q;
    rslt_d = rslt_q;
    eoc_d = eoc_q & ~rd_clr;
    ovr_d = (ar_fire && hit(araddr, OFF_STATUS)) ? '0 : ovr_q;
    if (wr_fire && hit(aw_addr_q, OFF_MODE)) mode_d = (mode_q & ~wr_m) | (w_data_q & wr_m);
    if (wr_fire && hit(aw_addr_q, OFF_CH_ON)) ch_en_d = ch_en_q | wr_eff[NUM_CH-1:0];
    if (wr_fire && hit(aw_addr_q, OFF_CH_OFF)) ch_en_d = ch_en_q & ~wr_eff[NUM_CH-1:0];
    if (wr_fire && hit(aw_addr_q, OFF_IRQ_ON)) imr_d = imr_q | (wr_eff[STAT_W-1:0] & STAT_MASK);
    if (wr_fire && hit(aw_addr_q, OFF_IRQ_OFF)) imr_d = imr_q & ~wr_eff[STAT_W-1:0];
    unique case (state_q)
      S_IDLE: begin
        if (start_req) begin
          rem_d = ch_en_q;
          if (sw_start) eoc_d = '0;
          if (sleep) begin
            state_d = S_WAKE;
            wake_d = WAKE_W'(WAKE_CYCLES - 1);
          end else begin
            state_d = S_PICK;
          end
        end
      end
      S_WAKE: begin
        if (wake_q == '0) state_d = S_PICK;
        else wake_d = wake_q - 1'b1;
      end
      S_PICK: begin
        if (rem_q == '0) begin
          state_d = S_IDLE;
        end else begin
          ch_d = cv.chan;
          rem_d[cv.chan] = 1'b0;
          state_d = S_WAIT;
        end
      end
      S_WAIT: begin
        if (cv.done) begin
          rslt_d[ch_q] = capture;
          // Set beats the read clear in the same cycle
          if (eoc_q[ch_q] && !rd_clr[ch_q]) ovr_d[ch_q] = 1'b1;
          eoc_d[ch_q] = 1'b1;
          state_d = S_PICK;
        end
      end
    endcase
    if (soft_rst) begin
      state_d = S_IDLE;
      mode_d = MODE_RESET;
      ch_en_d = '0;
      imr_d = '0;
      eoc_d = '0;
      ovr_d = '0;
      rem_d = '0;
      for (int i = 0; i < NUM_CH; i++) rslt_d[i] = '0;
    end
    stat_d = {ovr_d, 4'h0, eoc_d};
    irq_d = |(stat_d & imr_d);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      mode_q <= MODE_RESET;
      ch_en_q <= '0;
      imr_q <= '0;
      eoc_q <= '0;
      ovr_q <= '0;
      rem_q <= '0;
      ch_q <= '0;
      wake_q <= '0;
      irq_q <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) rslt_q[i] <= '0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      ch_en_q <= ch_en_d;
      imr_q <= imr_d;
      eoc_q <= eoc_d;
      ovr_q <= ovr_d;
      rem_q <= rem_d;
      ch_q <= ch_d;
      wake_q <= wake_d;
      irq_q <= irq_d;
      rslt_q <= rslt_d;
    end
  end

  // Cell stays powered between channels so only one start-up wait per sequence
  assign cell_power = !sleep || (state_q != S_IDLE);
  assign conv_irq   = irq_q;

  sequence s_done_taken;
    state_q == S_WAIT && cv.done && !soft_rst;
  endsequence
  sequence s_wake_entry;
    state_q == S_IDLE && start_req && sleep && !soft_rst;
  endsequence

  a_write_resp: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_fire |=> bvalid && !awready && !wready)
    else $error("write response missing");
  a_read_answer: assert property (@(posedge sys_clk) disable iff (!nrst)
    ar_fire |=> rvalid && rdata == $past(rd_mux))
    else $error("read answer wrong");
  a_eoc_on_done: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_done_taken |=> eoc_q[$past(ch_q)] && state_q == S_PICK)
    else $error("end flag not set");
  a_result_full: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_done_taken ##0 !mode_q[MODE_NARROW_BIT] |=> rslt_q[$past(ch_q)] == $past(cv.result))
    else $error("10-bit result not stored");
  a_result_low: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_done_taken ##0 mode_q[MODE_NARROW_BIT] |=> rslt_q[$past(ch_q)][RESULT_W-1:NARROW_W] == '0)
    else $error("8-bit result upper bits set");
  a_overrun_set: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_done_taken ##0 (eoc_q[ch_q] && !rd_clr[ch_q]) |=> ovr_q[$past(ch_q)])
    else $error("overrun not flagged");
  a_read_clears: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ar_fire && is_result(araddr) && !cv.done) |=> !eoc_q[$past(araddr[3:2])])
    else $error("end flag not cleared by read");
  a_start_clears: assert property (@(posedge sys_clk) disable iff (!nrst)
    (sw_start && !soft_rst && state_q == S_IDLE) |=> eoc_q == '0 && state_q != S_IDLE)
    else $error("start did not clear end flags");
  a_hw_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_q == S_IDLE && !sw_start && (!mode_q[MODE_HW_EN_BIT]
      || mode_q[MODE_HW_SEL_LSB +: HW_SEL_W] == HW_SEL_RSVD)) |=> state_q == S_IDLE)
    else $error("disabled trigger started a sequence");
  a_hw_edge: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_q == S_IDLE && hw_start && !soft_rst) |=> state_q != S_IDLE)
    else $error("trigger edge ignored");
  a_wake_wait: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_wake_entry |=> state_q == S_WAKE && wake_q == WAKE_W'(WAKE_CYCLES - 1))
    else $error("start-up wait skipped");
  a_sleep_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    (sleep && state_q == S_IDLE) |-> !cell_power && !cell_active)
    else $error("cell powered while asleep");
  a_channel_order: assert property (@(posedge sys_clk) disable iff (!nrst)
    cv.start |-> (rem_q & ((NUM_CH'(1) << cv.chan) - 1'b1)) == '0)
    else $error("channel order not ascending");
  a_seq_end: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_q == S_PICK && rem_q == '0) |=> state_q == S_IDLE)
    else $error("sequence did not end");
endmodule // sar_adc_sequencer

// File: tb/cell_model.sv
`timescale 1ns/10ps
module cell_model (
  input  wire logic [sar_adc_pkg::CH_IDX_W-1:0] cell_chan,
  input  wire logic                            cell_active,
  output logic [sar_adc_pkg::RESULT_W-1:0]      cell_data
);
  // Outside a conversion the held value is gone, so show its inverse
  assign cell_data = cell_active ? {cell_chan, 8'h5A} : ~{cell_chan, 8'h5A};
endmodule // cell_model

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import sar_adc_pkg::*;
  logic        sys_clk = 0, nrst = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [5:0]  tmr = 0;
  logic        ext = 0;
  logic [9:0]  cdata;
  logic [1:0]  cchan;
  logic        cact, cpwr, cclk, irq;
  logic [31:0] rd;
  logic [1:0]  rs, bs;
  int          err_count = 0, checked = 0;
  sar_adc_sequencer #(.WAKE_CYCLES(3)) sar_adc_sequencer_inst (
    .sys_clk(sys_clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .timer_wave_output(tmr), .ext_trigger_pin_0(ext), .cell_data(cdata), .cell_clk(cclk),
    .cell_chan(cchan), .cell_active(cact), .cell_power(cpwr), .conv_irq(irq));
  cell_model cell_model_inst (.cell_chan(cchan), .cell_active(cact), .cell_data(cdata));
  initial forever #50 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Ready sampled at the falling edge is what the next rising edge sees
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic at, wt, bt;
    @(posedge sys_clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(negedge sys_clk);
      at = awvalid && awready; wt = wvalid && wready; bt = bvalid;
      bs = bresp;
      @(posedge sys_clk);
      if (at) awvalid <= 0;
      if (wt) wvalid <= 0;
    end while (!bt);
    bready <= 0;
  endtask
  task automatic rdr(input logic [7:0] a);
    logic at, rt;
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(negedge sys_clk);
      at = arvalid && arready; rt = rvalid; rd = rdata; rs = rresp;
      @(posedge sys_clk);
      if (at) arvalid <= 0;
    end while (!rt);
    rready <= 0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    chk("reg", e, rd);
  endtask
  // Four channels at 22 cycles each plus wake-up and margin
  task automatic settle();
    repeat (150) @(posedge sys_clk);
  endtask
  task automatic pulse(input logic [5:0] t, input logic x);
    @(posedge sys_clk);
    tmr <= t; ext <= x;
    repeat (5) @(posedge sys_clk);
    tmr <= 0; ext <= 0;
    settle();
  endtask
  task automatic t_regs();
    rchk(OFF_MODE, 32'h00000000);
    rdr(8'h08);
    chk("unmapped", 32'h00000002, {30'h0, rs});
    wr(OFF_CH_ON, 32'h00000005);
    rchk(OFF_CH_STAT, 32'h00000005);
    wr(OFF_CH_OFF, 32'h00000001);
    wr(OFF_CH_ON, 32'h00000000);
    rchk(OFF_CH_STAT, 32'h00000004);
    wr(OFF_CH_ON, 32'h00000001);
  endtask
  task automatic t_seq();
    wr(OFF_CTRL, 32'h00000002);
    settle();
    rchk(OFF_STATUS, 32'h00000005);
    rchk(OFF_RESULT0, 32'h0000005A);
    rchk(OFF_RESULT0 + 8'h08, 32'h0000025A);
    rchk(OFF_STATUS, 32'h00000000);
  endtask
  task automatic t_trig();
    rdr(OFF_RESULT0);
    wr(OFF_MODE, 32'h0000000D);
    pulse(6'h00, 1'b1);
    rchk(OFF_STATUS, 32'h00000005);
    pulse(6'h00, 1'b1);
    rchk(OFF_STATUS, 32'h00000505);
    rchk(OFF_STATUS, 32'h00000005);
    rdr(OFF_RESULT0);
    rdr(OFF_RESULT0 + 8'h08);
    wr(OFF_MODE, 32'h0000000F);
    pulse(6'h3F, 1'b1);
    rchk(OFF_STATUS, 32'h00000000);
    wr(OFF_MODE, 32'h00000000);
    pulse(6'h01, 1'b1);
    rchk(OFF_STATUS, 32'h00000000);
    wr(OFF_MODE, 32'h00000001); // timer 0 assumed in waveform mode
    pulse(6'h01, 1'b0);
    rchk(OFF_STATUS, 32'h00000005);
  endtask
  task automatic t_low();
    wr(OFF_MODE, 32'h00000010);
    wr(OFF_CTRL, 32'h00000002);
    rchk(OFF_STATUS, 32'h00000000);
    settle();
    rchk(OFF_RESULT0 + 8'h08, 32'h0000005A);
  endtask
  task automatic t_sleep();
    wr(OFF_MODE, 32'h00000020);
    @(negedge sys_clk);
    chk("power", 0, cpwr);
    wr(OFF_CTRL, 32'h00000002);
    @(negedge sys_clk);
    chk("power", 1, cpwr);
    chk("active", 0, cact);
    settle();
    chk("power", 0, cpwr);
    rchk(OFF_STATUS, 32'h00000005);
  endtask
  // Prescaler 1 divides by 4: 11 conversion clocks take 44 cycles
  task automatic t_div();
    int   n = 0, r = 0;
    logic p = 0;
    wr(OFF_MODE, 32'h00000100);
    wr(OFF_CTRL, 32'h00000002);
    @(negedge sys_clk);
    while (!cact) @(negedge sys_clk);
    while (cact) begin
      n++;
      if (cclk && !p) r++;
      p = cclk;
      @(negedge sys_clk);
    end
    chk("active", 44, n);
    chk("clock", 11, r);
    settle();
  endtask
  task automatic t_irq();
    wr(OFF_IRQ_ON, 32'h00000001);
    rchk(OFF_IRQ_MSK, 32'h00000001);
    @(negedge sys_clk);
    chk("irq", 1, irq);
    rdr(OFF_RESULT0);
    @(negedge sys_clk);
    chk("irq", 0, irq);
    wr(8'h08, 32'h00000000);
    chk("bresp", 32'h00000002, {30'h0, bs});
    wr(OFF_CTRL, 32'h00000001);
    rchk(OFF_MODE, 32'h00000000);
    rchk(OFF_CH_STAT, 32'h00000000);
  endtask
  task automatic wrap_up();
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1;
    t_regs();
    t_seq();
    t_trig();
    t_low();
    t_sleep();
    t_div();
    t_irq();
    wrap_up();
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_count++;
    wrap_up();
  end
endmodule // testbench
